// ==== rtl/isc_pkg.sv ====
// Constants and types of the eleven-source interrupt controller.
// Operation
// - Level mode: flag follows inverted pin, never auto-cleared.
// - Edge mode: flag cleared when handler entered.
// - External inputs two, three behave like zero, one.
// - Timer 0/1 flags cleared on vectoring.
// - Timer 2 request: overflow OR capture flag.
// - Serial request: receive OR transmit flag.
// - Wake timer flag requests only when enabled.
// - Brown-out requests if reset-select 0, enable 1.
// - SPI flags share one request and vector.
// - Software-written flags request like hardware ones; level-mode external flags ignore writes and follow the pin.
// - Per-source enables, gated by global enable.
// - Uncleared flag re-enters its handler repeatedly.
// - Two-bit level: high and low register bits.
// - Preempt only by strictly higher level.
// - Equal level ties resolved by natural order.
// - Vector address 0003h plus eight per source.
// - Only externals, wake timer, brown-out wake core.
// - Sample, poll and resolve every machine cycle.
// - Call needs free level, last cycle, no blockers.
// - Blocked requests are not remembered.
// - Call pushes program counter, not status word.
// - Only handler return clears in-service level.
// - Edge: high sample then low sets flag.
// - Three cycles minimum from flag to handler.
package isc_pkg;
  localparam int NUM_SRC = 32'h0000000b;
  localparam int NUM_EXT = 32'h00000004;
  localparam int NUM_LVL = 32'h00000004;
  localparam int VEC_SHIFT = 32'h00000003;

  typedef logic [3:0] isc_idx_type;
  typedef logic [1:0] isc_lvl_type;

  // Natural order of the sources, first wins a tie.
  localparam isc_idx_type SRC_EXT0 = 4'h0;
  localparam isc_idx_type SRC_TMR0 = 4'h1;
  localparam isc_idx_type SRC_EXT1 = 4'h2;
  localparam isc_idx_type SRC_TMR1 = 4'h3;
  localparam isc_idx_type SRC_UART = 4'h4;
  localparam isc_idx_type SRC_TMR2 = 4'h5;
  localparam isc_idx_type SRC_EXT2 = 4'h6;
  localparam isc_idx_type SRC_EXT3 = 4'h7;
  localparam isc_idx_type SRC_SPI  = 4'h8;
  localparam isc_idx_type SRC_WAKE = 4'h9;
  localparam isc_idx_type SRC_BOD  = 4'ha;
  localparam isc_idx_type EXT_SRC [NUM_EXT] = '{SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3};

  // Vector of source zero; each next source sits eight bytes higher.
  localparam logic [15:0] VEC_BASE = 16'h0003;
  // Sources allowed to wake the core from power-down.
  localparam logic [10:0] WAKE_MASK = 11'h6c5;
  localparam logic [3:0]  IN_SERVICE_RST = 4'h0;
  localparam logic        PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_POLL    = 3'b001,
    ST_PUSH_LO = 3'b010,
    ST_PUSH_HI = 3'b100
  } isc_state_type;

  typedef struct packed {
    logic prev_pin;
    logic flag;
  } isc_ext_state_type;

  typedef struct packed {
    isc_state_type state;
    logic [3:0]    in_service;
    logic [1:0]    tmr_flag;
    logic          push_lo;
    logic          push_hi;
    logic          pc_load;
    logic [15:0]   pc_value;
    logic          wake_req;
  } isc_core_state_type;

  localparam isc_ext_state_type EXT_RST = '{prev_pin: PIN_IDLE, flag: 1'b0};
endpackage : isc_pkg

// ==== rtl/isc_ext_if.sv ====
// Link between the core and one external request flag.
`timescale 1ns/1ps
`default_nettype none
interface isc_ext_if;
  logic pin;
  logic edge_sel;
  logic sw_we;
  logic sw_wdata;
  logic vec_clr;
  logic flag;
  modport ctl (output pin, output edge_sel, output sw_we, output sw_wdata,
               output vec_clr, input flag);
  modport req (input pin, input edge_sel, input sw_we, input sw_wdata,
               input vec_clr, output flag);
endinterface : isc_ext_if
`default_nettype wire

// ==== rtl/isc_ext_req.sv ====
// One external request flag with level and falling-edge modes.
`timescale 1ns/1ps
`default_nettype none
module isc_ext_req (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Link to the core.
  isc_ext_if.req   bus
);
  import isc_pkg::*;

  isc_ext_state_type st;
  isc_ext_state_type next_st;

  // Pin sample history and flag update; a new edge wins over any clear.
  always_comb begin
    next_st = st;
    next_st.prev_pin = bus.pin;
    if (!bus.edge_sel) begin
      next_st.flag = ~bus.pin;
    end else begin
      if (bus.vec_clr) begin
        next_st.flag = 1'b0;
      end
      if (bus.sw_we) begin
        next_st.flag = bus.sw_wdata;
      end
      if (st.prev_pin && !bus.pin) begin
        next_st.flag = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= EXT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.flag = st.flag;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  lvl_track_a: assert property (!bus.edge_sel ##1 !bus.edge_sel |-> bus.flag == !$past(bus.pin))
    else $error("Level-mode flag does not follow the inverted pin.");
  edge_set_a: assert property (bus.edge_sel && !bus.pin && $past(bus.pin) |=> bus.flag)
    else $error("Falling edge did not set the flag.");
  edge_clr_a: assert property (bus.edge_sel && bus.vec_clr && !bus.sw_we && !(st.prev_pin && !bus.pin)
                               |=> !bus.flag)
    else $error("Edge flag not cleared on vectoring.");
endmodule : isc_ext_req
`default_nettype wire

// ==== rtl/isc_core.sv ====
// Eleven-source interrupt controller: flags, priority, vector call, in-service tracking.
`timescale 1ns/1ps
`default_nettype none
module isc_core (
  // Clock and reset; one clock edge is one machine cycle.
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // External request pins, low active, and their mode selects.
  input  wire logic [3:0]             ext_pin,
  input  wire logic [3:0]             edge_level_select,
  input  wire logic [3:0]             ext_flag_we,
  input  wire logic [3:0]             ext_flag_wdata,
  // Timer 0 and 1 overflow set pulses and software writes.
  input  wire logic [1:0]             timer_overflow_set,
  input  wire logic [1:0]             timer_flag_we,
  input  wire logic [1:0]             timer_flag_wdata,
  // Flags held by the peripherals themselves.
  input  wire logic                   timer2_overflow_flag,
  input  wire logic                   timer2_external_flag,
  input  wire logic                   serial_receive_flag,
  input  wire logic                   serial_transmit_flag,
  input  wire logic                   transfer_done_flag,
  input  wire logic                   mode_fault_flag,
  input  wire logic                   overrun_flag,
  input  wire logic                   wake_timer_flag,
  input  wire logic                   brownout_flag,
  input  wire logic                   brownout_reset_select,
  // Enables and priority bits, one per source in natural order.
  input  wire logic                   global_enable,
  input  wire logic [10:0]            src_enable,
  input  wire logic [10:0]            prio_high,
  input  wire logic [10:0]            prio_low,
  // Instruction sequencer status.
  input  wire logic                   last_cycle,
  input  wire logic                   writes_enable_prio,
  input  wire logic                   return_from_handler,
  // Flags held here.
  output logic [3:0]                  external_request_flag,
  output logic [1:0]                  timer_overflow_flag,
  // Vector call to the sequencer and program counter.
  output logic                        push_pc_low,
  output logic                        push_pc_high,
  output logic                        pc_load,
  output logic [15:0]                 pc_load_value,
  // Level status and power-down wake.
  output logic [3:0]                  in_service,
  output logic                        wake_request
);
  import isc_pkg::*;

  isc_core_state_type st;
  isc_core_state_type next_st;
  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] src_req;
  logic [NUM_EXT-1:0] ext_flag;
  logic               found;
  isc_idx_type        grant_idx;
  isc_lvl_type        grant_lvl;
  logic               act_valid;
  isc_lvl_type        act_lvl;
  logic               grant;

  isc_ext_if ext_bus [NUM_EXT] ();

  // External inputs two and three reuse the same flag module as zero and one.
  for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
    assign ext_bus[g].pin      = ext_pin[g];
    assign ext_bus[g].edge_sel = edge_level_select[g];
    assign ext_bus[g].sw_we    = ext_flag_we[g];
    assign ext_bus[g].sw_wdata = ext_flag_wdata[g];
    assign ext_bus[g].vec_clr  = grant && (grant_idx == EXT_SRC[g]);
    assign ext_flag[g]         = ext_bus[g].flag;
    isc_ext_req u_req (
      .clk_sys (clk_sys),
      .srst    (srst),
      .bus     (ext_bus[g])
    );
  end

  // Gather each source's flag; shared flags are ORed into one request.
  always_comb begin
    src_flag           = '0;
    src_flag[SRC_EXT0] = ext_flag[0];
    src_flag[SRC_TMR0] = st.tmr_flag[0];
    src_flag[SRC_EXT1] = ext_flag[1];
    src_flag[SRC_TMR1] = st.tmr_flag[1];
    src_flag[SRC_UART] = serial_receive_flag | serial_transmit_flag;
    src_flag[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
    src_flag[SRC_EXT2] = ext_flag[2];
    src_flag[SRC_EXT3] = ext_flag[3];
    src_flag[SRC_SPI]  = transfer_done_flag | mode_fault_flag | overrun_flag;
    src_flag[SRC_WAKE] = wake_timer_flag;
    src_flag[SRC_BOD]  = brownout_flag & ~brownout_reset_select;
  end

  // Individual enables pass a request only while the global enable is set.
  assign src_req = src_flag & src_enable & {NUM_SRC{global_enable}};

  // Poll every cycle: the highest level wins, a tie goes to the lowest index.
  always_comb begin
    found     = 1'b0;
    grant_idx = SRC_EXT0;
    grant_lvl = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (src_req[i] && (!found || {prio_high[i], prio_low[i]} > grant_lvl)) begin
        found     = 1'b1;
        grant_idx = isc_idx_type'(i);
        grant_lvl = {prio_high[i], prio_low[i]};
      end
    end
  end

  // Highest level now in service.
  always_comb begin
    act_valid = 1'b0;
    act_lvl   = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (st.in_service[l]) begin
        act_valid = 1'b1;
        act_lvl   = isc_lvl_type'(l);
      end
    end
  end

  // Call only from the last cycle of a harmless instruction, above the active level.
  // A refused request leaves no trace and must still be asserted at a later poll.
  assign grant = (st.state == ST_POLL) && found
                 && (!act_valid || grant_lvl > act_lvl)
                 && last_cycle && !writes_enable_prio && !return_from_handler;

  // Next-state logic for flags, call sequence and in-service bits.
  always_comb begin
    next_st = st;
    next_st.push_lo  = 1'b0;
    next_st.push_hi  = 1'b0;
    next_st.pc_load  = 1'b0;
    next_st.wake_req = |(src_flag & src_enable & WAKE_MASK);
    // Timer 0/1 flags: vectoring clears, a write replaces, a set wins.
    for (int t = 0; t < 2; t++) begin
      if (grant && grant_idx == (t == 0 ? SRC_TMR0 : SRC_TMR1)) begin
        next_st.tmr_flag[t] = 1'b0;
      end
      if (timer_flag_we[t]) begin
        next_st.tmr_flag[t] = timer_flag_wdata[t];
      end
      if (timer_overflow_set[t]) begin
        next_st.tmr_flag[t] = 1'b1;
      end
    end
    // A plain return leaves the bits alone; only the handler return pops a level.
    if (return_from_handler && act_valid) begin
      next_st.in_service[act_lvl] = 1'b0;
    end
    unique case (st.state)
      ST_POLL: begin
        if (grant) begin
          next_st.state                 = ST_PUSH_LO;
          next_st.push_lo               = 1'b1;
          next_st.in_service[grant_lvl] = 1'b1;
          // Sources without auto-clear keep their flag and re-enter after return.
          next_st.pc_value = VEC_BASE + (16'(grant_idx) << VEC_SHIFT);
        end
      end
      ST_PUSH_LO: begin
        next_st.state   = ST_PUSH_HI;
        next_st.push_hi = 1'b1;
        next_st.pc_load = 1'b1;
      end
      ST_PUSH_HI: begin
        next_st.state = ST_POLL;
      end
    endcase
  end

  // State register; reset clears the call sequence and all in-service levels.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.state      <= ST_POLL;
      st.in_service <= IN_SERVICE_RST;
      st.tmr_flag   <= '0;
      st.push_lo    <= 1'b0;
      st.push_hi    <= 1'b0;
      st.pc_load    <= 1'b0;
      st.pc_value   <= VEC_BASE;
      st.wake_req   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign external_request_flag = ext_flag;
  assign timer_overflow_flag   = st.tmr_flag;
  assign push_pc_low           = st.push_lo;
  assign push_pc_high          = st.push_hi;
  assign pc_load               = st.pc_load;
  assign pc_load_value         = st.pc_value;
  assign in_service            = st.in_service;
  assign wake_request          = st.wake_req;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  call_seq_a: assert property (grant |=> push_pc_low && !pc_load ##1 push_pc_high && pc_load
                               ##1 !push_pc_low && !pc_load)
    else $error("Vector call sequence is not two cycles.");
  block_cond_a: assert property ((!last_cycle || writes_enable_prio || return_from_handler)
                                 |=> !push_pc_low)
    else $error("Vector call issued despite a blocking condition.");
  top_level_a: assert property (in_service[3] |-> !grant)
    else $error("Highest level handler was preempted.");
  equal_lvl_a: assert property (grant && act_valid |-> grant_lvl > act_lvl)
    else $error("Preempted by equal or lower level.");
  vec_addr_a: assert property (grant && grant_idx == SRC_BOD |=> ##1 pc_load
                               && pc_load_value == 16'h0053)
    else $error("Brown-out vector address wrong.");
  bod_gate_a: assert property (brownout_reset_select |-> !(grant && grant_idx == SRC_BOD))
    else $error("Brown-out requested while reset-select set.");
  tmr_clr_a: assert property (grant && grant_idx == SRC_TMR0 && !timer_overflow_set[0]
                              && !timer_flag_we[0] |=> !timer_overflow_flag[0])
    else $error("Timer 0 flag not cleared on vectoring.");
  return_from_handler_pop_a: assert property (return_from_handler && in_service != 4'h0 |=>
                               $countones(in_service) == $countones($past(in_service)) - 1)
    else $error("Handler return did not clear exactly one level.");
  set_level_a: assert property (grant |=> in_service[$past(grant_lvl)])
    else $error("Granted level not marked in service.");
  global_off_a: assert property (!global_enable |-> !grant)
    else $error("Call issued with global enable off.");
  t2_keep_a: assert property (grant && grant_idx == SRC_TMR2 |-> found)
    else $error("Timer 2 grant without a request.");
endmodule : isc_core
`default_nettype wire

// ==== test/isc_cpu_model.sv ====
// Behavioural instruction sequencer that faces the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module isc_cpu_model (
  // Clock and reset.
  input  wire logic  clk_sys,
  input  wire logic  srst,
  // When high, every instruction lasts two machine cycles.
  input  wire logic  slow,
  // Vector call from the controller.
  input  wire logic  push_pc_low,
  input  wire logic  push_pc_high,
  input  wire logic  pc_load,
  // Sequencer status and call bookkeeping.
  output logic       last_cycle,
  output logic [7:0] call_cnt,
  output logic       pair_bad
);
  logic phase;
  logic low_seen;

  // A stretched instruction ends only on every other machine cycle.
  assign last_cycle = ~slow | phase;

  // Count calls and flag any call whose two push cycles come out of order.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase <= 1'b0;
      low_seen <= 1'b0;
      call_cnt <= 8'h00;
      pair_bad <= 1'b0;
    end else begin
      phase <= ~phase;
      low_seen <= push_pc_low;
      call_cnt <= call_cnt + {7'h00, pc_load};
      pair_bad <= pair_bad | (push_pc_high != low_seen) | (pc_load != push_pc_high);
    end
  end
endmodule : isc_cpu_model
`default_nettype wire

// ==== test/eleven_source_interrupt_controller_test.sv ====
// Self-checking bench for the eleven-source interrupt controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end
module eleven_source_interrupt_controller_test;
  import isc_pkg::*;
  logic        clk_sys, srst, slow, pc_load, push_pc_low, push_pc_high, pair_bad, wake_request;
  logic [3:0]  ext_pin, edge_level_select, ext_flag_we, ext_flag_wdata;
  logic [3:0]  external_request_flag, in_service;
  logic [1:0]  timer_overflow_set, timer_flag_we, timer_flag_wdata, timer_overflow_flag;
  logic        timer2_overflow_flag, timer2_external_flag, serial_receive_flag;
  logic        serial_transmit_flag, transfer_done_flag, mode_fault_flag, overrun_flag;
  logic        wake_timer_flag, brownout_flag, brownout_reset_select, global_enable;
  logic [10:0] src_enable, prio_high, prio_low;
  logic        last_cycle, writes_enable_prio, return_from_handler;
  logic [15:0] pc_load_value;
  logic [7:0]  call_cnt;
  logic [8:0]  pf;
  int          error_cnt = 0;
  int          samples_checked = 0;

  // Peripheral-owned flags, one bit each.
  assign {brownout_flag, wake_timer_flag, overrun_flag, mode_fault_flag, transfer_done_flag,
          timer2_external_flag, timer2_overflow_flag, serial_transmit_flag,
          serial_receive_flag} = pf;

  isc_core dut (.clk_sys, .srst, .ext_pin, .edge_level_select, .ext_flag_we, .ext_flag_wdata,
    .timer_overflow_set, .timer_flag_we, .timer_flag_wdata, .timer2_overflow_flag,
    .timer2_external_flag, .serial_receive_flag, .serial_transmit_flag, .transfer_done_flag,
    .mode_fault_flag, .overrun_flag, .wake_timer_flag, .brownout_flag, .brownout_reset_select,
    .global_enable, .src_enable, .prio_high, .prio_low, .last_cycle, .writes_enable_prio,
    .return_from_handler, .external_request_flag, .timer_overflow_flag, .push_pc_low,
    .push_pc_high, .pc_load, .pc_load_value, .in_service, .wake_request);

  isc_cpu_model cpu (.clk_sys, .srst, .slow, .push_pc_low, .push_pc_high, .pc_load,
    .last_cycle, .call_cnt, .pair_bad);

  // Clock of 200 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Raise the sources in the mask; pins and timer pulses last one cycle.
  task automatic raise(input logic [10:0] m);
    @(posedge clk_sys);
    ext_pin <= ~{m[7], m[6], m[2], m[0]};
    timer_overflow_set <= {m[3], m[1]};
    pf <= pf | {m[10], m[9], m[8], 2'b00, m[5], 2'b00, m[4]};
    @(posedge clk_sys);
    ext_pin <= 4'hf;
    timer_overflow_set <= 2'b00;
  endtask : raise

  // Wait a bounded time for the vector load and check its address.
  task automatic expect_call(input logic [15:0] v);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (pc_load !== 1'b1 && n < 16) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(pc_load, 1'b1)
    `CHK(pc_load_value, v)
  endtask : expect_call

  // No vector call may happen for eight cycles; a call still finishing is counted first.
  task automatic no_call();
    logic [7:0] c;
    @(posedge clk_sys);
    @(negedge clk_sys);
    c = call_cnt;
    cyc(8);
    @(negedge clk_sys);
    `CHK(call_cnt, c)
  endtask : no_call

  // Handler return instruction, one cycle long.
  task automatic ret();
    @(posedge clk_sys) return_from_handler <= 1'b1;
    @(posedge clk_sys) return_from_handler <= 1'b0;
  endtask : ret

  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake.
  initial begin
    cyc(20000);
    error_cnt++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {ext_flag_we, ext_flag_wdata, timer_overflow_set, timer_flag_we, timer_flag_wdata} = '0;
    {ext_pin, edge_level_select} = 8'hff;
    {pf, brownout_reset_select, src_enable, prio_high, prio_low} = '0;
    {writes_enable_prio, return_from_handler, slow} = 3'b000;
    global_enable = 1'b1;
    srst = 1'b1;
    cyc(16);
    srst <= 1'b0;
    @(negedge clk_sys);
    `CHK({in_service, push_pc_low, pc_load}, 6'h00)
    `CHK(pc_load_value, 16'h0003)
    // Every source alone at level zero, in natural order.
    for (int i = 0; i < 11; i++) begin
      src_enable <= 11'h001 << i;
      raise(11'h001 << i);
      expect_call(16'h0003 + 16'(i * 8));
      `CHK(in_service, 4'h1)
      if (i < 4 || i == 6 || i == 7) begin
        `CHK({external_request_flag, timer_overflow_flag}, 6'h00)
      end else begin
        ret();
        expect_call(16'h0003 + 16'(i * 8));
        @(posedge clk_sys) pf <= '0;
      end
      ret();
      cyc(4);
      `CHK(in_service, 4'h0)
    end
    // Each member of the shared requests, with stretched instructions.
    slow <= 1'b1;
    src_enable <= 11'h7ff;
    for (int j = 0; j < 7; j++) begin
      @(posedge clk_sys) pf <= 9'h001 << j;
      expect_call(16'h0003 + 16'((j < 2 ? 4 : j < 4 ? 5 : 8) * 8));
      @(posedge clk_sys) pf <= '0;
      ret();
      cyc(4);
    end
    slow <= 1'b0;
    // Tie at equal level, then preemption by a raised level.
    raise(11'h00c);
    expect_call(16'h0013);
    no_call();
    @(posedge clk_sys) prio_low <= 11'h008;
    expect_call(16'h001b);
    `CHK(in_service, 4'h3)
    ret();
    cyc(2);
    `CHK(in_service, 4'h1)
    ret();
    @(posedge clk_sys) prio_low <= '0;
    // Level mode and wake with the global enable off.
    global_enable <= 1'b0;
    edge_level_select <= 4'he;
    ext_pin <= 4'he;
    cyc(3);
    `CHK(external_request_flag, 4'h1)
    `CHK(wake_request, 1'b1)
    @(posedge clk_sys) ext_pin <= 4'hf;
    ext_flag_we <= 4'h1;
    ext_flag_wdata <= 4'h1;
    @(posedge clk_sys) ext_flag_we <= 4'h0;
    cyc(2);
    `CHK({external_request_flag, wake_request}, 5'h00)
    edge_level_select <= 4'hf;
    timer_flag_we <= 2'b01;
    timer_flag_wdata <= 2'b01;
    @(posedge clk_sys) timer_flag_we <= 2'b00;
    no_call();
    `CHK({timer_overflow_flag, wake_request}, 3'h2)
    global_enable <= 1'b1;
    expect_call(16'h000b);
    ret();
    @(posedge clk_sys) ext_flag_we <= 4'h4;
    ext_flag_wdata <= 4'h4;
    @(posedge clk_sys) ext_flag_we <= 4'h0;
    expect_call(16'h0033);
    ret();
    // Brown-out held back by its reset select.
    @(posedge clk_sys) brownout_reset_select <= 1'b1;
    pf <= 9'h100;
    no_call();
    @(posedge clk_sys) brownout_reset_select <= 1'b0;
    expect_call(16'h0053);
    @(posedge clk_sys) pf <= '0;
    ret();
    // A blocked request is forgotten once its flag drops.
    @(posedge clk_sys) writes_enable_prio <= 1'b1;
    pf <= 9'h002;
    no_call();
    @(posedge clk_sys) pf <= '0;
    @(posedge clk_sys) writes_enable_prio <= 1'b0;
    no_call();
    `CHK(pair_bad, 1'b0)
    report_and_stop();
  end
endmodule : eleven_source_interrupt_controller_test
`default_nettype wire
